// ### serial_boot_flash_loader.sv
// Serial boot protocol engine with UART, password and page programming
`timescale 1ns/10ps
`default_nettype none
module serial_boot_flash_loader #(
    parameter int CLK_HZ = sbl_pkg::CLK_HZ,
    parameter int FLASH_BYTES = sbl_pkg::FLASH_BYTES,
    parameter logic [7:0] BAUD_CODE [sbl_pkg::NUM_CODES] =
        sbl_pkg::BAUD_CODE_DEF,
    parameter int BAUD_RATE [sbl_pkg::NUM_CODES] = sbl_pkg::BAUD_RATE_DEF
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic rxd,
    output logic txd,
    output logic [15:0] memAddr,
    output logic memRead,
    input wire logic [7:0] memRdata,
    output logic flashWe,
    output logic [15:0] flashAddr,
    output logic [7:0] flashData,
    output logic flashCommit,
    input wire logic flashBusy,
    output logic halted
);
    localparam logic [15:0] INIT_DIV = 16'(CLK_HZ / sbl_pkg::INIT_BAUD);
    localparam logic [15:0] LAST_SUM = 16'(FLASH_BYTES - 1);

    if (CLK_HZ / 4800 > 60000 || FLASH_BYTES > 65536 ||
        sbl_pkg::PAGE_BYTES != 32) begin : g_bad_cfg
        $error("Unsupported clock, flash size or page size");
    end

    typedef enum logic [4:0] {
        S_SYNC, S_BAUD, S_CMD, S_TX_WAIT, S_ERR_TX, S_ADDR, S_CAP_CNT,
        S_BLANK_RD, S_BLANK_CAP, S_PW_RX, S_PW_CMP, S_REC_MARK, S_REC_HDR,
        S_REC_DATA, S_REC_CHK, S_COPY, S_PROG, S_PROG_WAIT, S_SUM_RD,
        S_SUM_CAP, S_SUM_LO, S_HALT
    } state_t;

    typedef struct packed {
        state_t st;
        state_t after;
        logic [15:0] div;
        logic [1:0] trial;
        logic [15:0] pendDiv;
        logic applyDiv;
        logic rxBusy;
        logic [15:0] rxCnt;
        logic [3:0] rxBits;
        logic [7:0] rxShift;
        logic rxValid;
        logic rxFerr;
        logic [7:0] rxByte;
        logic txGo;
        logic [7:0] txByte;
        logic txBusy;
        logic [15:0] txCnt;
        logic [3:0] txBits;
        logic [9:0] txShift;
        logic txd;
        logic [1:0] errLeft;
        logic [1:0] idx;
        logic [15:0] cntAddr;
        logic [15:0] cmpAddr;
        logic [7:0] pwLeft;
        logic blank;
        logic [4:0] vecIdx;
        logic [7:0] recLen;
        logic [7:0] recType;
        logic [7:0] recSum;
        logic [7:0] recI;
        logic [15:0] recAddr;
        logic [15:0] pageBase;
        logic [31:0] pageMask;
        logic [5:0] progIdx;
        logic [15:0] sumCnt;
        logic [15:0] imageChecksum;
        logic [15:0] memAddr;
        logic memRead;
        logic flashWe;
        logic [15:0] flashAddr;
        logic [7:0] flashData;
        logic flashCommit;
        logic halted;
    } regs_t;

    regs_t s;
    regs_t next_s;
    logic [7:0] recBuf [256];
    logic [7:0] pageBuf [sbl_pkg::PAGE_BYTES];
    logic recWe;
    logic [7:0] recWa;
    logic pageWe;
    logic [4:0] pageWa;
    logic [7:0] pageWd;
    logic [16:0] codeHit;
    logic [15:0] copyAddr;

    // Baud code lookup: {found, divisor}
    function automatic logic [16:0] codeDiv(input logic [7:0] code);
        logic [16:0] r;
        r = '0;
        for (int i = 0; i < sbl_pkg::NUM_CODES; i++) begin
            if (BAUD_CODE[i] == code) begin
                r = {1'b1, 16'(CLK_HZ / BAUD_RATE[i])};
            end
        end
        return r;
    endfunction

    // Trial divisors around the 9600 rate
    function automatic logic [15:0] trialDiv(input logic [1:0] t);
        case (t)
            2'h0: trialDiv = INIT_DIV;
            2'h1: trialDiv = INIT_DIV + (INIT_DIV >> 5);
            2'h2: trialDiv = INIT_DIV - (INIT_DIV >> 5);
            default: trialDiv = INIT_DIV + (INIT_DIV >> 4);
        endcase
    endfunction

    always_comb begin
        next_s = s;
        next_s.rxValid = 1'b0;
        next_s.rxFerr = 1'b0;
        next_s.txGo = 1'b0;
        next_s.memRead = 1'b0;
        next_s.flashWe = 1'b0;
        next_s.flashCommit = 1'b0;
        recWe = 1'b0;
        recWa = s.recI;
        pageWe = 1'b0;
        pageWa = '0;
        pageWd = '0;
        codeHit = codeDiv(s.rxByte);
        copyAddr = 16'(s.recAddr + 16'(s.recI));
        // Receiver
        if (!s.halted) begin
            if (!s.rxBusy) begin
                if (!rxd) begin
                    next_s.rxBusy = 1'b1;
                    next_s.rxCnt = (s.div >> 1) - 16'h0001;
                    next_s.rxBits = '0;
                end
            end else if (s.rxCnt != 16'h0000) begin
                next_s.rxCnt = s.rxCnt - 16'h0001;
            end else begin
                next_s.rxCnt = s.div - 16'h0001;
                if (s.rxBits == 4'h0) begin
                    next_s.rxBusy = !rxd;
                    next_s.rxBits = 4'h1;
                end else if (s.rxBits != 4'h9) begin
                    next_s.rxShift = {rxd, s.rxShift[7:1]};
                    next_s.rxBits = s.rxBits + 4'h1;
                end else begin
                    next_s.rxBusy = 1'b0;
                    next_s.rxValid = rxd;
                    next_s.rxFerr = !rxd;
                    next_s.rxByte = s.rxShift;
                end
            end
        end
        // Transmitter
        if (s.txGo) begin
            next_s.txBusy = 1'b1;
            next_s.txShift = {1'b1, s.txByte, 1'b0};
            next_s.txd = 1'b0;
            next_s.txCnt = s.div - 16'h0001;
            next_s.txBits = '0;
        end else if (s.txBusy) begin
            if (s.txCnt != 16'h0000) begin
                next_s.txCnt = s.txCnt - 16'h0001;
            end else if (s.txBits == 4'h9) begin
                next_s.txBusy = 1'b0;
                next_s.txd = 1'b1;
            end else begin
                next_s.txCnt = s.div - 16'h0001;
                next_s.txShift = {1'b1, s.txShift[9:1]};
                next_s.txd = s.txShift[1];
                next_s.txBits = s.txBits + 4'h1;
            end
        end
        // Receive errors after sync end the session silently
        if (s.rxFerr && s.st != S_SYNC && s.st != S_HALT) begin
            next_s.st = S_HALT;
            next_s.txBusy = 1'b0;
            next_s.txd = 1'b1;
            next_s.halted = 1'b1;
        end else begin
            case (s.st)
                S_SYNC: begin
                    if (s.rxValid && s.rxByte == sbl_pkg::SYNC_BYTE) begin
                        next_s.div = INIT_DIV;
                        next_s.txByte = sbl_pkg::SYNC_BYTE;
                        next_s.txGo = 1'b1;
                        next_s.after = S_BAUD;
                        next_s.st = S_TX_WAIT;
                    end else if (s.rxValid || s.rxFerr) begin
                        next_s.trial = s.trial + 2'h1;
                        next_s.div = trialDiv(s.trial + 2'h1);
                    end
                end
                S_BAUD: begin
                    if (s.rxValid) begin
                        if (codeHit[16]) begin
                            next_s.txByte = s.rxByte;
                            next_s.txGo = 1'b1;
                            next_s.pendDiv = codeHit[15:0];
                            next_s.applyDiv = 1'b1;
                            next_s.after = S_CMD;
                            next_s.st = S_TX_WAIT;
                        end else begin
                            next_s.txByte = sbl_pkg::ERR_BAUD;
                            next_s.errLeft = sbl_pkg::ERR_REPEAT;
                            next_s.st = S_ERR_TX;
                        end
                    end
                end
                S_CMD: begin
                    if (s.rxValid) begin
                        next_s.txByte = s.rxByte;
                        next_s.idx = '0;
                        if (s.rxByte == sbl_pkg::CMD_FLASH) begin
                            next_s.txGo = 1'b1;
                            next_s.after = S_ADDR;
                            next_s.st = S_TX_WAIT;
                        end else if (s.rxByte == sbl_pkg::CMD_RAM) begin
                            next_s.txGo = 1'b1;
                            next_s.after = S_HALT;
                            next_s.st = S_TX_WAIT;
                        end else begin
                            next_s.txByte = sbl_pkg::ERR_CMD;
                            next_s.errLeft = sbl_pkg::ERR_REPEAT;
                            next_s.st = S_ERR_TX;
                        end
                    end
                end
                S_TX_WAIT: begin
                    if (!s.txBusy && !s.txGo) begin
                        if (s.applyDiv) begin
                            next_s.div = s.pendDiv;
                        end
                        next_s.applyDiv = 1'b0;
                        next_s.st = s.after;
                        next_s.halted = (s.after == S_HALT);
                    end
                end
                S_ERR_TX: begin
                    if (!s.txBusy && !s.txGo) begin
                        if (s.errLeft == 2'h0) begin
                            next_s.st = S_HALT;
                            next_s.halted = 1'b1;
                        end else begin
                            next_s.txGo = 1'b1;
                            next_s.errLeft = s.errLeft - 2'h1;
                        end
                    end
                end
                S_ADDR: begin
                    if (s.rxValid) begin
                        next_s.idx = s.idx + 2'h1;
                        case (s.idx)
                            2'h0: next_s.cntAddr[15:8] = s.rxByte;
                            2'h1: next_s.cntAddr[7:0] = s.rxByte;
                            2'h2: next_s.cmpAddr[15:8] = s.rxByte;
                            default: begin
                                next_s.cmpAddr[7:0] = s.rxByte;
                                next_s.memAddr = s.cntAddr;
                                next_s.memRead = 1'b1;
                                next_s.st = S_CAP_CNT;
                            end
                        endcase
                    end
                end
                S_CAP_CNT: begin
                    next_s.pwLeft = memRdata;
                    next_s.blank = 1'b1;
                    next_s.vecIdx = '0;
                    next_s.st = S_BLANK_RD;
                end
                S_BLANK_RD: begin
                    next_s.memAddr = sbl_pkg::VEC_FIRST | 16'(s.vecIdx);
                    next_s.memRead = 1'b1;
                    next_s.st = S_BLANK_CAP;
                end
                S_BLANK_CAP: begin
                    next_s.blank = s.blank && memRdata == sbl_pkg::BLANK_BYTE;
                    next_s.vecIdx = s.vecIdx + 5'h01;
                    if (s.vecIdx != sbl_pkg::VEC_LAST_IDX) begin
                        next_s.st = S_BLANK_RD;
                    end else if (s.pwLeft == 8'h00) begin
                        next_s.st = S_REC_MARK;
                    end else begin
                        next_s.st = S_PW_RX;
                    end
                end
                S_PW_RX: begin
                    if (s.rxValid) begin
                        next_s.memAddr = s.cmpAddr;
                        next_s.memRead = 1'b1;
                        next_s.st = S_PW_CMP;
                    end
                end
                S_PW_CMP: begin
                    if (!s.blank && memRdata != s.rxByte) begin
                        next_s.st = S_HALT;
                        next_s.halted = 1'b1;
                    end else begin
                        next_s.cmpAddr = s.cmpAddr + 16'h0001;
                        next_s.pwLeft = s.pwLeft - 8'h01;
                        next_s.st = (s.pwLeft == 8'h01) ? S_REC_MARK : S_PW_RX;
                    end
                end
                S_REC_MARK: begin
                    if (s.rxValid && s.rxByte == sbl_pkg::REC_MARK) begin
                        next_s.idx = '0;
                        next_s.recSum = '0;
                        next_s.recI = '0;
                        next_s.st = S_REC_HDR;
                    end
                end
                S_REC_HDR: begin
                    if (s.rxValid) begin
                        next_s.recSum = s.recSum + s.rxByte;
                        next_s.idx = s.idx + 2'h1;
                        case (s.idx)
                            2'h0: next_s.recLen = s.rxByte;
                            2'h1: next_s.recAddr[15:8] = s.rxByte;
                            2'h2: next_s.recAddr[7:0] = s.rxByte;
                            default: begin
                                next_s.recType = s.rxByte;
                                next_s.st = (s.recLen == 8'h00) ?
                                    S_REC_CHK : S_REC_DATA;
                            end
                        endcase
                    end
                end
                S_REC_DATA: begin
                    if (s.rxValid) begin
                        recWe = 1'b1;
                        next_s.recSum = s.recSum + s.rxByte;
                        next_s.recI = s.recI + 8'h01;
                        if (s.recI == s.recLen - 8'h01) begin
                            next_s.st = S_REC_CHK;
                        end
                    end
                end
                S_REC_CHK: begin
                    if (s.rxValid) begin
                        next_s.recI = '0;
                        next_s.sumCnt = '0;
                        next_s.imageChecksum = '0;
                        next_s.progIdx = '0;
                        if (8'(s.recSum + s.rxByte) != 8'h00) begin
                            next_s.st = S_HALT;
                            next_s.halted = 1'b1;
                        end else if (s.recType == sbl_pkg::REC_DATA) begin
                            next_s.st = S_COPY;
                        end else if (s.recType == sbl_pkg::REC_END) begin
                            next_s.after = S_SUM_RD;
                            next_s.st = (s.pageMask != '0) ? S_PROG : S_SUM_RD;
                        end else begin
                            next_s.st = S_REC_MARK;
                        end
                    end
                end
                S_COPY: begin
                    if (s.recI == s.recLen) begin
                        next_s.st = S_REC_MARK;
                    end else if (s.pageMask != '0 &&
                        copyAddr[15:5] != s.pageBase[15:5]) begin
                        next_s.after = S_COPY;
                        next_s.st = S_PROG;
                    end else begin
                        pageWe = 1'b1;
                        pageWa = copyAddr[4:0];
                        pageWd = recBuf[s.recI];
                        next_s.pageMask[copyAddr[4:0]] = 1'b1;
                        next_s.pageBase = {copyAddr[15:5], 5'h00};
                        next_s.recI = s.recI + 8'h01;
                    end
                end
                S_PROG: begin
                    if (s.progIdx[5]) begin
                        next_s.flashCommit = 1'b1;
                        next_s.flashAddr = s.pageBase;
                        next_s.st = S_PROG_WAIT;
                    end else begin
                        next_s.flashWe = s.pageMask[s.progIdx[4:0]];
                        next_s.flashAddr = s.pageBase | 16'(s.progIdx[4:0]);
                        next_s.flashData = pageBuf[s.progIdx[4:0]];
                        next_s.progIdx = s.progIdx + 6'h01;
                    end
                end
                S_PROG_WAIT: begin
                    if (!flashBusy && !s.flashCommit) begin
                        next_s.pageMask = '0;
                        next_s.progIdx = '0;
                        next_s.st = s.after;
                    end
                end
                S_SUM_RD: begin
                    next_s.memAddr = 16'(sbl_pkg::FLASH_BASE + s.sumCnt);
                    next_s.memRead = 1'b1;
                    next_s.st = S_SUM_CAP;
                end
                S_SUM_CAP: begin
                    next_s.imageChecksum = s.imageChecksum + 16'(memRdata);
                    next_s.sumCnt = s.sumCnt + 16'h0001;
                    next_s.st = S_SUM_RD;
                    if (s.sumCnt == LAST_SUM) begin
                        next_s.txByte = next_s.imageChecksum[15:8];
                        next_s.txGo = 1'b1;
                        next_s.after = S_SUM_LO;
                        next_s.st = S_TX_WAIT;
                    end
                end
                S_SUM_LO: begin
                    next_s.txByte = s.imageChecksum[7:0];
                    next_s.txGo = 1'b1;
                    next_s.after = S_CMD;
                    next_s.st = S_TX_WAIT;
                end
                default: begin
                    next_s.halted = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            s <= '0;
            s.st <= S_SYNC;
            s.after <= S_SYNC;
            s.div <= INIT_DIV;
            s.txd <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Record and page staging memories
    always_ff @(posedge core_clk) begin
        if (recWe) begin
            recBuf[recWa] <= s.rxByte;
        end
        if (pageWe) begin
            pageBuf[pageWa] <= pageWd;
        end
    end

    assign txd = s.txd;
    assign memAddr = s.memAddr;
    assign memRead = s.memRead;
    assign flashWe = s.flashWe;
    assign flashAddr = s.flashAddr;
    assign flashData = s.flashData;
    assign flashCommit = s.flashCommit;
    assign halted = s.halted;
endmodule // serial_boot_flash_loader
`default_nettype wire

// ### sbl_pkg.sv
// Constants for the serial boot flash loader
// Function
// - Match sync 5AH, then run at 9600
// - Echo 5AH; on failure retry another rate
// - Echo valid rate code, switch after echo
// - Invalid rate code: send 62H thrice, halt
// - Command 30H selects flash write, echoed
// - Unknown command: send 63H thrice, halt
// - Bytes 7 and 9 form count address
// - Bytes 11 and 13 form compare address
// - Receive error in address bytes: silent halt
// - Compare N password bytes against memory
// - Password mismatch halts silently
// - All-FFH vector area skips password check
// - Discard bytes silently until 3AH mark
// - Parse length, address, type, data, checksum
// - Stage data, program flash in 32-byte pages
// - Receive or format error: silent halt
// - End record: send 16-bit sum, high first
// - After sum, wait for next command
// - Command 60H echoed, then halt
`default_nettype none
package sbl_pkg;
    localparam logic [7:0] SYNC_BYTE = 8'h5A;
    localparam logic [7:0] BAUD_DEFAULT = 8'h28;
    localparam logic [7:0] CMD_FLASH = 8'h30;
    localparam logic [7:0] CMD_RAM = 8'h60;
    localparam logic [7:0] ERR_BAUD = 8'h62;
    localparam logic [7:0] ERR_CMD = 8'h63;
    localparam logic [7:0] REC_MARK = 8'h3A;
    localparam logic [7:0] REC_DATA = 8'h00;
    localparam logic [7:0] REC_END = 8'h01;
    localparam logic [7:0] BLANK_BYTE = 8'hFF;
    localparam logic [1:0] ERR_REPEAT = 2'h3;
    localparam logic [15:0] VEC_FIRST = 16'hFFE0;
    localparam logic [4:0] VEC_LAST_IDX = 5'h1F;
    localparam int PAGE_BYTES = 32;
    localparam int PAGE_BITS = 5;
    localparam logic [15:0] FLASH_BASE = 16'hE000;
    localparam int FLASH_BYTES = 8192;
    localparam int CLK_HZ = 125_000_000;
    localparam int INIT_BAUD = 9600;
    localparam int NUM_CODES = 6;
    localparam logic [7:0] BAUD_CODE_DEF [NUM_CODES] =
        '{8'h18, 8'h28, 8'h3C, 8'h50, 8'h64, 8'h78};
    localparam int BAUD_RATE_DEF [NUM_CODES] =
        '{4800, 9600, 19200, 38400, 57600, 115200};
endpackage
`default_nettype wire

// ### sbl_sva.sv
// Port checker for the serial boot flash loader
`timescale 1ns/10ps
`default_nettype none
module sbl_sva (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic txd,
    input wire logic memRead,
    input wire logic flashWe,
    input wire logic [15:0] flashAddr,
    input wire logic flashCommit,
    input wire logic halted
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    reset_idle_a: assert property (disable iff (1'b0)
        !resetn |=> txd && !halted) else $error("busy after reset");
    halt_quiet_a: assert property (halted |-> txd)
        else $error("transmit after halt");
    halt_stays_a: assert property (halted |=> halted)
        else $error("halt released");
    halt_nowrite_a: assert property (
        halted |-> !flashWe && !flashCommit)
        else $error("flash activity after halt");
    page_base_a: assert property (
        flashCommit |-> flashAddr[4:0] == 5'h00)
        else $error("commit not on page base");
    page_order_a: assert property (flashWe ##1 flashWe |->
        flashAddr > $past(flashAddr)) else $error("page bytes out of order");
    read_spaced_a: assert property (memRead |=> !memRead)
        else $error("reads back to back");
    start_bit_a: assert property ($fell(txd) |=> !txd [*3])
        else $error("start bit too short");
    cover property ($rose(halted));
    cover property (flashCommit);
    cover property (memRead ##2 memRead);
endmodule // sbl_sva
bind serial_boot_flash_loader sbl_sva u_sva (.core_clk, .resetn, .txd,
    .memRead, .flashWe, .flashAddr, .flashCommit, .halted);
`default_nettype wire

// ### sbl_host.sv
// Programming controller model on the UART link
`timescale 1ns/10ps
`default_nettype none
module sbl_host (
    input wire logic core_clk,
    input wire logic txd,
    output logic rxd
);
    int div = 32;
    initial rxd = 1'b1;
    task automatic put(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd <= f[i];
            repeat (div) @(posedge core_clk);
        end
    endtask
    task automatic get(input int lim, output logic [8:0] r);
        r = 9'h000;
        lim = lim + 12 * div;
        while (txd && lim > 0) begin
            @(posedge core_clk);
            lim--;
        end
        if (txd) return;
        repeat (div / 2) @(posedge core_clk);
        for (int i = 0; i < 9; i++) begin
            repeat (div) @(posedge core_clk);
            r[i] = txd;
        end
    endtask
endmodule // sbl_host
`default_nettype wire

// ### serial_boot_flash_loader_test.sv
// Self-checking bench for the serial boot flash loader
`timescale 1ns/10ps
`default_nettype none
module serial_boot_flash_loader_test;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic flashBusy = 1'b0;
    logic rxd, txd, memRead, flashWe, flashCommit, halted;
    logic [15:0] memAddr, flashAddr;
    logic [7:0] flashData;
    logic [7:0] mem [0:65535];
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    always #4 core_clk = ~core_clk;
    serial_boot_flash_loader #(.CLK_HZ(307200), .FLASH_BYTES(64)) uut (
        .core_clk, .resetn, .rxd, .txd, .memAddr, .memRead,
        .memRdata(mem[memAddr]), .flashWe, .flashAddr, .flashData,
        .flashCommit, .flashBusy, .halted);
    sbl_host host (.core_clk, .txd, .rxd);
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        flashBusy <= flashCommit;
        if (flashWe)
            mem[flashAddr] <= flashData;
        if (cyc == 60000) begin
            n_errors++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string w, input logic [15:0] e, g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic xch(input logic [7:0] b, input int lim, output logic [8:0] r);
        fork
            host.put(b);
            host.get(lim, r);
        join
    endtask
    task automatic send(input logic [7:0] b, input logic [8:0] e);
        logic [8:0] r;
        xch(b, 0, r);
        chk("reply", {7'h0, e}, {7'h0, r});
    endtask
    task automatic open();
        logic [8:0] r;
        resetn <= 1'b0;
        host.div = 32;
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        xch(8'h00, 0, r);
        chk("sync refused", 16'h0000, {7'h0, r});
        for (int i = 0; i < 6 && r !== 9'h15A; i++)
            xch(8'h5A, 0, r);
        chk("sync echo", 16'h015A, {7'h0, r});
    endtask
    task automatic err3(input logic [7:0] e);
        repeat (2) begin
            send(8'h00, {1'b1, e});
        end
        repeat (100) @(posedge core_clk);
        chk("halted", 16'h1, {15'h0, halted});
        send(8'h5A, 9'h000);
    endtask
    task automatic t_rates();
        logic [7:0] c;
        for (int k = 0; k < 7; k++) begin
            open();
            if (k == 6) begin
                send(8'h11, 9'h162);
                err3(8'h62);
            end else begin
                c = sbl_pkg::BAUD_CODE_DEF[k];
                send(c, {1'b1, c});
                repeat (64) @(posedge core_clk);
                host.div = 307200 / sbl_pkg::BAUD_RATE_DEF[k];
                if (k < 5)
                    send(8'h30, 9'h130);
            end
        end
        $display("rates test done");
    endtask
    task automatic t_cmds();
        open();
        send(8'h28, 9'h128);
        send(8'h44, 9'h163);
        err3(8'h63);
        open();
        send(8'h28, 9'h128);
        send(8'h60, 9'h160);
        repeat (40) @(posedge core_clk);
        chk("halted", 16'h1, {15'h0, halted});
        $display("command test done");
    endtask
    task automatic head(input logic blank);
        for (int i = 0; i < 32; i++)
            mem[16'hFFE0 + i] = blank ? 8'hFF : 8'h12;
        mem[16'h0010] = 8'h02;
        mem[16'h0020] = 8'hA5;
        mem[16'h0021] = 8'h3C;
        open();
        send(8'h28, 9'h128);
        send(8'h30, 9'h130);
        send(8'h00, 9'h000);
        send(8'h10, 9'h000);
        send(8'h00, 9'h000);
        send(8'h20, 9'h000);
    endtask
    task automatic t_pass(input logic blank);
        head(blank);
        send(8'hA5, 9'h000);
        send(8'h00, 9'h000);
        repeat (50) @(posedge core_clk);
        chk("halted", {15'h0, !blank}, {15'h0, halted});
        $display("password test done");
    endtask
    task automatic t_flash();
        logic [7:0] s [16] = '{8'hA5, 8'h3C, 8'h55, 8'h3A, 8'h02, 8'hE0,
            8'h00, 8'h00, 8'h11, 8'h22, 8'hEB, 8'h3A, 8'h00, 8'h00,
            8'h00, 8'h01};
        logic [8:0] r;
        head(1'b0);
        for (int i = 0; i < 16; i++) begin
            if (i == 11)
                repeat (400) @(posedge core_clk);
            send(s[i], 9'h000);
        end
        xch(8'hFF, 3000, r);
        chk("sum high", 16'h0101, {7'h0, r});
        host.get(0, r);
        chk("sum low", 16'h0143, {7'h0, r});
        chk("page", 16'h1122, {mem[16'hE000], mem[16'hE001]});
        send(8'h30, 9'h130);
        $display("flash test done");
    endtask
    initial begin
        for (int i = 0; i < 64; i++)
            mem[16'hE000 + i] = 8'h00;
        mem[16'h0000] = 8'h00;
        mem[16'hE002] = 8'h80;
        mem[16'hE03F] = 8'h90;
        t_rates();
        t_cmds();
        t_pass(1'b0);
        t_pass(1'b1);
        t_flash();
        conclude();
    end
endmodule // serial_boot_flash_loader_test
`default_nettype wire
